// File: hdl/cfu_defs.svh
`ifndef CFU_DEFS_SVH
`define CFU_DEFS_SVH

// Result word layout
`define CFU_WORD_W 16
`define CFU_WORD_MSB 15
`define CFU_ZERO_WORD 16'h0000

// Program address and save slots
`define CFU_PC_W 32
`define CFU_SLOT_W 5

// Unified word address map
`define CFU_UADDR_W 16
`define CFU_WORK_BASE 16'h1000
`define CFU_WORK_WORDS 16'h0200
`define CFU_WORK_LAST 16'h01ff
`define CFU_TIMER_PV_BASE 16'h1200
`define CFU_DM_BASE 16'h8000

// System words and bit written on a stop after an instruction error
`define CFU_FAULT_ADDR_LO_WORD 16'h012a
`define CFU_FAULT_ADDR_HI_WORD 16'h012b
`define CFU_FAULT_BIT_WORD 16'h0127
`define CFU_FAULT_BIT_POS 4'h8

`endif

// File: hdl/cfu_pkg.sv
`default_nettype none
`include "cfu_defs.svh"

package cfu_pkg;

   // One bit per condition flag
   typedef struct packed {
      logic error_flag;
      logic equals_flag;
      logic carry_flag;
      logic less_than_flag;
      logic greater_than_flag;
      logic negative_flag;
      logic overflow_flag;
      logic underflow_flag;
   } cfu_flags_t;

   // Instruction classes as far as the flags care
   typedef enum logic [2:0] {
      CFU_K_OTHER,
      CFU_K_MOVE,
      CFU_K_FLAG_SAVE,
      CFU_K_FLAG_LOAD
   } cfu_kind_t;

   // Memory areas reachable by a multi-word operand
   typedef enum logic [1:0] {
      CFU_AREA_WORK,
      CFU_AREA_TIMER_PV,
      CFU_AREA_DM
   } cfu_area_t;

   // One executed instruction as seen from the datapath
   typedef struct packed {
      logic exec;
      logic differentiated;
      logic diff_edge;
      cfu_kind_t kind;
      logic fault;
      logic clr_err;
      logic neg_msb;
      cfu_flags_t wr_mask;
      cfu_flags_t value;
      logic [`CFU_WORD_W-1:0] result;
      logic [`CFU_WORD_W-1:0] src;
      logic [`CFU_PC_W-1:0] pc;
      logic [`CFU_SLOT_W-1:0] slot;
   } cfu_req_t;

   // Multi-word operand walk request
   typedef struct packed {
      logic start;
      cfu_area_t area;
      logic [`CFU_UADDR_W-1:0] offset;
      logic [`CFU_UADDR_W-1:0] count;
   } cfu_walk_req_t;

   typedef enum logic {
      CFU_RUN,
      CFU_HALT
   } cfu_state_t;

   typedef enum logic {
      CFU_W_IDLE,
      CFU_W_BUSY
   } cfu_walk_state_t;

endpackage : cfu_pkg

`default_nettype wire

// File: hdl/cfu_save_mem.sv
`timescale 1ns/10ps
`default_nettype none

module cfu_save_mem #(
   parameter int WIDTH = 8,
   parameter int ADDR_W = 5
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [ADDR_W-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data_q
);

   logic [WIDTH-1:0] mem_q [0:(1<<ADDR_W)-1];

   ////////////////////////////////////////////////////////////////////////
   // Write port
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem_q[wr_addr] <= wr_data;
      end
   end

   // Registered read port
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_q <= '0;
      end else begin
         rd_data_q <= mem_q[rd_addr];
      end
   end

endmodule : cfu_save_mem

`default_nettype wire

// File: hdl/cfu_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "cfu_defs.svh"

module cfu_top (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire cfu_pkg::cfu_req_t REQ,
   input wire logic STOP_ON_ERROR,
   input wire logic INT_ENTER,
   input wire logic INT_RETURN,
   input wire cfu_pkg::cfu_walk_req_t WALK_REQ,
   output cfu_pkg::cfu_flags_t FLAGS,
   output logic INSTR_DONE,
   output logic INSTR_SUPPRESSED,
   output logic HALTED,
   output logic [`CFU_WORD_W-1:0] FAULT_ADDR_LO,
   output logic [`CFU_WORD_W-1:0] FAULT_ADDR_HI,
   output logic FAULT_STOP_BIT,
   output logic [`CFU_UADDR_W-1:0] WALK_ADDR,
   output logic WALK_VALID,
   output logic WALK_BUSY
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   cfu_pkg::cfu_flags_t flags_q;
   cfu_pkg::cfu_flags_t flags_d;
   cfu_pkg::cfu_flags_t shadow_q;
   cfu_pkg::cfu_flags_t load_data;
   cfu_pkg::cfu_state_t state_q;
   cfu_pkg::cfu_walk_state_t wstate_q;
   logic fire;
   logic stop_now;
   logic load_pend_q;
   logic [`CFU_UADDR_W-1:0] waddr_q;
   logic [`CFU_UADDR_W-1:0] wleft_q;

   // Unified address of a word in an area
   function automatic logic [`CFU_UADDR_W-1:0] unified_addr(
      input cfu_pkg::cfu_area_t area,
      input logic [`CFU_UADDR_W-1:0] offset
   );
      logic [`CFU_UADDR_W-1:0] base;
      base = `CFU_DM_BASE;
      case (area)
         cfu_pkg::CFU_AREA_WORK: base = `CFU_WORK_BASE;
         cfu_pkg::CFU_AREA_TIMER_PV: base = `CFU_TIMER_PV_BASE;
         default: base = `CFU_DM_BASE;
      endcase
      unified_addr = base + offset;
   endfunction : unified_addr

   ////////////////////////////////////////////////////////////////////////
   // Instruction acceptance
   always_comb begin
      // Differentiated ones act only in their edge cycle
      fire = REQ.exec && (state_q == cfu_pkg::CFU_RUN)
             && (!REQ.differentiated || REQ.diff_edge);
      stop_now = fire && REQ.fault && !REQ.clr_err && STOP_ON_ERROR;
   end

   // Next flag values for one executed instruction
   always_comb begin
      flags_d = flags_q;
      if (REQ.clr_err) begin
         flags_d.error_flag = 1'b0;
      end else if (REQ.fault) begin
         flags_d.error_flag = 1'b1;
      end else if (REQ.wr_mask.error_flag) begin
         flags_d.error_flag = REQ.value.error_flag;
      end
      if (REQ.wr_mask.equals_flag) begin
         flags_d.equals_flag = REQ.value.equals_flag;
      end
      // Negative is written by every executed instruction except flag save and load, fault or not
      flags_d.negative_flag = REQ.neg_msb ? REQ.result[`CFU_WORD_MSB] : 1'b0;
      if (!REQ.fault || REQ.clr_err) begin
         if (REQ.wr_mask.carry_flag) begin
            flags_d.carry_flag = REQ.value.carry_flag;
         end
         if (REQ.wr_mask.less_than_flag) begin
            flags_d.less_than_flag = REQ.value.less_than_flag;
         end
         if (REQ.wr_mask.greater_than_flag) begin
            flags_d.greater_than_flag = REQ.value.greater_than_flag;
         end
         if (REQ.wr_mask.overflow_flag) begin
            flags_d.overflow_flag = REQ.value.overflow_flag;
         end
         if (REQ.wr_mask.underflow_flag) begin
            flags_d.underflow_flag = REQ.value.underflow_flag;
         end
         if (REQ.kind == cfu_pkg::CFU_K_MOVE) begin
            flags_d.equals_flag = (REQ.src == `CFU_ZERO_WORD);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Flag register
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         flags_q <= '0;
      end else if (INT_RETURN) begin
         flags_q <= shadow_q;
      end else if (load_pend_q) begin
         flags_q <= load_data;
      end else if (fire && REQ.kind != cfu_pkg::CFU_K_FLAG_SAVE
                   && REQ.kind != cfu_pkg::CFU_K_FLAG_LOAD) begin
         flags_q <= flags_d;
      end
   end

   // Interrupt shadow copy
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         shadow_q <= '0;
      end else if (INT_ENTER) begin
         shadow_q <= flags_q;
      end
   end

   // Flag load waits one cycle for the save memory read
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         load_pend_q <= 1'b0;
      end else begin
         load_pend_q <= fire && (REQ.kind == cfu_pkg::CFU_K_FLAG_LOAD);
      end
   end

   // Save slots for flag save and load
   cfu_save_mem #(
      .WIDTH($bits(cfu_pkg::cfu_flags_t)),
      .ADDR_W(`CFU_SLOT_W)
   ) u_save_mem (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .wr_en(fire && (REQ.kind == cfu_pkg::CFU_K_FLAG_SAVE)),
      .wr_addr(REQ.slot),
      .wr_data(flags_q),
      .rd_addr(REQ.slot),
      .rd_data_q(load_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // Run and halt on instruction error
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_q <= cfu_pkg::CFU_RUN;
      end else begin
         case (state_q)
            cfu_pkg::CFU_RUN: begin
               if (stop_now) begin
                  state_q <= cfu_pkg::CFU_HALT;
               end
            end
            cfu_pkg::CFU_HALT: state_q <= cfu_pkg::CFU_HALT;
            default: state_q <= cfu_pkg::CFU_RUN;
         endcase
      end
   end

   // Fault address words and stop bit
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         FAULT_ADDR_LO <= '0;
         FAULT_ADDR_HI <= '0;
         FAULT_STOP_BIT <= 1'b0;
      end else if (stop_now) begin
         FAULT_ADDR_LO <= REQ.pc[`CFU_WORD_W-1:0];
         FAULT_ADDR_HI <= REQ.pc[`CFU_PC_W-1:`CFU_WORD_W];
         FAULT_STOP_BIT <= 1'b1;
      end
   end

   // Completion report to the sequencer
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         INSTR_DONE <= 1'b0;
         INSTR_SUPPRESSED <= 1'b0;
      end else begin
         INSTR_DONE <= fire;
         INSTR_SUPPRESSED <= fire && REQ.fault && !REQ.clr_err;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Multi-word operand walker, one unified address per cycle
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         wstate_q <= cfu_pkg::CFU_W_IDLE;
         waddr_q <= '0;
         wleft_q <= '0;
      end else begin
         case (wstate_q)
            cfu_pkg::CFU_W_IDLE: begin
               if (WALK_REQ.start && WALK_REQ.count != '0) begin
                  waddr_q <= unified_addr(WALK_REQ.area, WALK_REQ.offset);
                  wleft_q <= WALK_REQ.count;
                  wstate_q <= cfu_pkg::CFU_W_BUSY;
               end
            end
            cfu_pkg::CFU_W_BUSY: begin
               // Area end is not a boundary: timer values follow work word 511
               waddr_q <= waddr_q + 16'h0001;
               wleft_q <= wleft_q - 16'h0001;
               if (wleft_q == 16'h0001) begin
                  wstate_q <= cfu_pkg::CFU_W_IDLE;
               end
            end
            default: wstate_q <= cfu_pkg::CFU_W_IDLE;
         endcase
      end
   end

   // Walker outputs
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         WALK_ADDR <= '0;
         WALK_VALID <= 1'b0;
         WALK_BUSY <= 1'b0;
      end else begin
         WALK_ADDR <= waddr_q;
         WALK_VALID <= (wstate_q == cfu_pkg::CFU_W_BUSY);
         WALK_BUSY <= (wstate_q == cfu_pkg::CFU_W_BUSY) || WALK_REQ.start;
      end
   end

   // Status outputs
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         FLAGS <= '0;
         HALTED <= 1'b0;
      end else begin
         FLAGS <= flags_q;
         HALTED <= (state_q == cfu_pkg::CFU_HALT);
      end
   end

endmodule : cfu_top

`default_nettype wire

// File: tb/cfu_seq_model.sv
`timescale 1ns/10ps
`default_nettype none

// Sequencer side: held rung condition to one-scan edge
module cfu_seq_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cond,
   output logic diff_edge
);
   logic cond_q;
   logic prev_q;

   ////////////////////////////////////////////////////////////
   // Condition in this and the previous scan
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cond_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         cond_q <= cond;
         prev_q <= cond_q;
      end
   end

   // Edge only in first scan of a held condition
   assign diff_edge = cond_q & ~prev_q;
endmodule : cfu_seq_model

`default_nettype wire

// File: tb/cfu_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none
`include "cfu_defs.svh"

// Port watcher for the flag unit
module cfu_chk (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire cfu_pkg::cfu_req_t REQ,
   input wire logic STOP_ON_ERROR,
   input wire logic INT_RETURN,
   input wire cfu_pkg::cfu_walk_req_t WALK_REQ,
   input wire cfu_pkg::cfu_flags_t FLAGS,
   input wire logic INSTR_DONE,
   input wire logic INSTR_SUPPRESSED,
   input wire logic HALTED,
   input wire logic [`CFU_WORD_W-1:0] FAULT_ADDR_LO,
   input wire logic [`CFU_WORD_W-1:0] FAULT_ADDR_HI,
   input wire logic FAULT_STOP_BIT,
   input wire logic [`CFU_UADDR_W-1:0] WALK_ADDR,
   input wire logic WALK_VALID,
   input wire logic WALK_BUSY
);
   logic take;
   logic src_zero;
   logic neg_x;
   logic [4:0] hold_v;
   logic [`CFU_UADDR_W-1:0] wbase;

   default clocking cfu_cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);

   ////////////////////////////////////////////////////////////
   // Helper terms
   // Stop bit rises with the internal halt, one edge before the halted output
   assign take = REQ.exec && !FAULT_STOP_BIT && !INT_RETURN && (!REQ.differentiated || REQ.diff_edge);
   assign src_zero = REQ.src == `CFU_ZERO_WORD;
   assign neg_x = REQ.neg_msb & REQ.result[`CFU_WORD_MSB];
   assign hold_v = {FLAGS.carry_flag, FLAGS.less_than_flag, FLAGS.greater_than_flag,
                    FLAGS.overflow_flag, FLAGS.underflow_flag};
   assign wbase = (WALK_REQ.area == cfu_pkg::CFU_AREA_WORK ? `CFU_WORK_BASE :
                   WALK_REQ.area == cfu_pkg::CFU_AREA_TIMER_PV ? `CFU_TIMER_PV_BASE : `CFU_DM_BASE)
                  + WALK_REQ.offset;

   ////////////////////////////////////////////////////////////
   done_and_sup_a:
      assert property (take |=> INSTR_DONE && INSTR_SUPPRESSED == $past(REQ.fault && !REQ.clr_err))
      else $error("done");
   diff_refuse_a:
      assert property (REQ.exec && REQ.differentiated && !REQ.diff_edge |=> !INSTR_DONE) else $error("diff");
   move_equals_a:
      assert property (take && REQ.kind == cfu_pkg::CFU_K_MOVE && !REQ.fault
                       |-> ##2 FLAGS.equals_flag == $past(src_zero, 2)) else $error("equals");
   fault_hold_a:
      assert property (take && REQ.fault && !REQ.clr_err
                       |-> ##2 FLAGS.error_flag && hold_v == $past(hold_v, 1)) else $error("hold");
   clear_error_a:
      assert property (take && REQ.clr_err |-> ##2 !FLAGS.error_flag) else $error("clear");
   negative_msb_a:
      assert property (take && !REQ.fault && REQ.kind == cfu_pkg::CFU_K_OTHER
                       |-> ##2 FLAGS.negative_flag == $past(neg_x, 2)) else $error("negative");
   stop_record_a:
      assert property (take && REQ.fault && !REQ.clr_err && STOP_ON_ERROR |=> FAULT_STOP_BIT
                       && {FAULT_ADDR_HI, FAULT_ADDR_LO} == $past(REQ.pc) ##1 HALTED) else $error("stop");
   no_stop_a:
      assert property (take && REQ.fault && !STOP_ON_ERROR && !FAULT_STOP_BIT |-> ##2 !HALTED)
      else $error("halt");
   walk_start_a:
      assert property (WALK_REQ.start && !WALK_BUSY && WALK_REQ.count != 16'h0000
                       |=> WALK_BUSY ##1 WALK_VALID && WALK_ADDR == $past(wbase, 2)) else $error("walk");
   walk_step_a:
      assert property (WALK_VALID ##1 WALK_VALID |-> WALK_ADDR == $past(WALK_ADDR) + 16'h0001)
      else $error("step");
   flags_hold_a:
      assert property ((!take && !INT_RETURN) [*3] |=> $stable(FLAGS)) else $error("stable");

   // Main scenarios
   cover property (take && REQ.kind == cfu_pkg::CFU_K_FLAG_LOAD);
   cover property (WALK_VALID && WALK_ADDR == `CFU_TIMER_PV_BASE);
   cover property ($rose(HALTED));
endmodule : cfu_chk

bind cfu_top cfu_chk cfu_chk_inst (.SYS_CLK, .RST_N, .REQ, .STOP_ON_ERROR, .INT_RETURN, .WALK_REQ,
   .FLAGS, .INSTR_DONE, .INSTR_SUPPRESSED, .HALTED, .FAULT_ADDR_LO, .FAULT_ADDR_HI, .FAULT_STOP_BIT,
   .WALK_ADDR, .WALK_VALID, .WALK_BUSY);

`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "cfu_defs.svh"

module tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic stop = 1'b0;
   logic int_en = 1'b0;
   logic int_ret = 1'b0;
   logic cond = 1'b0;
   logic dedge, sup_seen, done, sup, halted, stop_bit, wvalid, wbusy;
   logic [15:0] lo, hi, waddr;
   int error_cnt = 0;
   int checks = 0;
   cfu_pkg::cfu_req_t req_q = '0;
   cfu_pkg::cfu_req_t req_in, r;
   cfu_pkg::cfu_walk_req_t walk_q = '0;
   cfu_pkg::cfu_flags_t flags;

   ////////////////////////////////////////////////////////////
   // Clock, edge from the sequencer model
   always #25 clk = ~clk;
   always_comb begin
      req_in = req_q;
      req_in.diff_edge = dedge;
   end

   cfu_seq_model cfu_seq_model_inst (.clk(clk), .rst_n(rst_n), .cond(cond), .diff_edge(dedge));
   cfu_top cfu_top_inst (.SYS_CLK(clk), .RST_N(rst_n), .REQ(req_in), .STOP_ON_ERROR(stop),
      .INT_ENTER(int_en), .INT_RETURN(int_ret), .WALK_REQ(walk_q), .FLAGS(flags), .INSTR_DONE(done),
      .INSTR_SUPPRESSED(sup), .HALTED(halted), .FAULT_ADDR_LO(lo), .FAULT_ADDR_HI(hi),
      .FAULT_STOP_BIT(stop_bit), .WALK_ADDR(waddr), .WALK_VALID(wvalid), .WALK_BUSY(wbusy));

   ////////////////////////////////////////////////////////////
   // Compare, build, issue, report
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   function automatic cfu_pkg::cfu_req_t mk(input cfu_pkg::cfu_kind_t k, input logic [7:0] m, input logic [7:0] v);
      mk = '0;
      mk.exec = 1'b1;
      mk.kind = k;
      mk.wr_mask = m;
      mk.value = v;
   endfunction : mk

   // One instruction, then done and flags
   task automatic op(input cfu_pkg::cfu_req_t q, input logic [7:0] ef, input logic ed);
      @(posedge clk);
      req_q <= q;
      @(posedge clk);
      req_q.exec <= 1'b0;
      #1;
      chk("done", 32'(ed), 32'(done));
      sup_seen = sup;
      repeat (2) @(posedge clk);
      #1;
      chk("flags", 32'(ef), 32'(flags));
   endtask : op

   // One operand walk, every word address in turn, then the end
   task automatic walk(input cfu_pkg::cfu_area_t a, input logic [15:0] ofs, input logic [15:0] n,
                       input logic [15:0] base);
      @(posedge clk);
      walk_q <= '{1'b1, a, ofs, n};
      @(posedge clk);
      walk_q.start <= 1'b0;
      #1;
      for (int i = 0; i < 8 && wvalid !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      for (int i = 0; i < int'(n); i++) begin
         chk("walk", 32'(base + ofs + 16'(i)), 32'(waddr));
         @(posedge clk);
         #1;
      end
      chk("walk end", 32'h0, 32'(wvalid));
   endtask : walk

   task automatic conclude;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : conclude

   ////////////////////////////////////////////////////////////
   // Watchdog
   initial begin
      repeat (3000) @(posedge clk);
      error_cnt++;
      conclude();
   end

   // Test sequence
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk("reset", 32'h0, 32'(flags));
      op(mk(cfu_pkg::CFU_K_OTHER, 8'h3b, 8'h30), 8'h30, 1'b1);
      repeat (5) @(posedge clk);
      #1;
      chk("held", 32'h30, 32'(flags));
      r = mk(cfu_pkg::CFU_K_OTHER, 8'h00, 8'h00);
      r.neg_msb = 1'b1;
      r.result = 16'h8000;
      op(r, 8'h34, 1'b1);
      r.neg_msb = 1'b0;
      op(r, 8'h30, 1'b1);
      r = mk(cfu_pkg::CFU_K_MOVE, 8'h40, 8'h00);
      op(r, 8'h70, 1'b1);
      r.src = 16'h0200;
      r.value = 8'h40;
      op(r, 8'h30, 1'b1);
      $display("test basic done");
      r = mk(cfu_pkg::CFU_K_OTHER, 8'hfb, 8'h4f);
      r.fault = 1'b1;
      op(r, 8'hf0, 1'b1);
      chk("suppressed", 32'h1, 32'(sup_seen));
      chk("halted", 32'h0, 32'(halted));
      r = mk(cfu_pkg::CFU_K_OTHER, 8'h00, 8'h00);
      r.clr_err = 1'b1;
      op(r, 8'h70, 1'b1);
      $display("test error done");
      r = mk(cfu_pkg::CFU_K_FLAG_SAVE, 8'h00, 8'h00);
      r.slot = 5'h03;
      op(r, 8'h70, 1'b1);
      op(mk(cfu_pkg::CFU_K_OTHER, 8'hfb, 8'h0b), 8'h0b, 1'b1);
      r.kind = cfu_pkg::CFU_K_FLAG_LOAD;
      op(r, 8'h70, 1'b1);
      $display("test save done");
      @(posedge clk);
      cond <= 1'b1;
      r = mk(cfu_pkg::CFU_K_OTHER, 8'h18, 8'h08);
      r.differentiated = 1'b1;
      op(r, 8'h68, 1'b1);
      r.value = 8'h10;
      op(r, 8'h68, 1'b0);
      $display("test differentiated done");
      @(posedge clk);
      int_en <= 1'b1;
      @(posedge clk);
      int_en <= 1'b0;
      op(mk(cfu_pkg::CFU_K_OTHER, 8'hfb, 8'h00), 8'h00, 1'b1);
      @(posedge clk);
      int_ret <= 1'b1;
      @(posedge clk);
      int_ret <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("restore", 32'h68, 32'(flags));
      $display("test interrupt done");
      walk(cfu_pkg::CFU_AREA_WORK, 16'h01fe, 16'h0004, `CFU_WORK_BASE);
      walk(cfu_pkg::CFU_AREA_TIMER_PV, 16'h0005, 16'h0001, `CFU_TIMER_PV_BASE);
      walk(cfu_pkg::CFU_AREA_DM, 16'h0010, 16'h0002, `CFU_DM_BASE);
      chk("walk error", 32'h0, 32'(flags.error_flag));
      $display("test walk done");
      @(posedge clk);
      stop <= 1'b1;
      r = mk(cfu_pkg::CFU_K_OTHER, 8'h00, 8'h00);
      r.fault = 1'b1;
      r.pc = 32'h0001_2345;
      op(r, 8'he8, 1'b1);
      chk("fault addr", 32'h0001_2345, {hi, lo});
      chk("stop bit", 32'h1, 32'(stop_bit));
      chk("halted", 32'h1, 32'(halted));
      op(mk(cfu_pkg::CFU_K_OTHER, 8'hfb, 8'h00), 8'he8, 1'b0);
      $display("test stop done");
      conclude();
   end
endmodule : tb_top

`default_nettype wire
